// *** bench/i2c_register_bank_autoinc_test.sv ***
// Self-checking bench of the serial register bank.
// Assumes the host model paces the serial lines and the wire has a pull-up.
`timescale 1ns/100ps
module i2c_register_bank_autoinc_test
  import irb_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  logic             sys_clk;    // 250 MHz system clock.
  logic             sys_rst;    // Synchronous reset.
  logic             scl_drv;    // Host serial clock.
  logic             sda_drv;    // Host data drive.
  logic             sda_wire;   // Resolved data wire.
  logic             sda_out;    // Device data value.
  logic             sda_oe;     // Device pull-down enable.
  logic             otp_load;   // Programmed-bit load pulse.
  logic [IMG_W-1:0] otp_image;  // Programmed values.
  logic [IMG_W-1:0] reg_image;  // Register contents.
  logic [IMG_W-1:0] exp_img;    // Shadow of what the bank should hold.
  logic             a;          // Scratch acknowledge.
  int               compares;   // Comparisons made.
  int               bad_count;  // Mismatches seen.

  // Rows: register index, byte written, byte expected on read back.
  logic [23:0] rows [9] = '{24'h00ff02, 24'h01ff00, 24'h02ff3f, 24'h05aa2a, 24'h0aff1f,
                            24'h12ff77, 24'h14ff5f, 24'h135a5a, 24'h1f7700};

  // The wire is low when either party pulls; otherwise the pull-up wins.
  assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);

  irb_bank_top #(.DEV_ADDR(DEV_ADDR_DEFAULT)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_drv), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .otp_load(otp_load), .otp_image(otp_image),
    .reg_image(reg_image));

  irb_host_model host (
    .sys_clk(sys_clk), .sda_wire(sda_wire), .scl_drv(scl_drv), .sda_drv(sda_drv));

  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock, 4 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Compares with case equality so an unknown never passes.
  task automatic check(input logic [IMG_W-1:0] got, input logic [IMG_W-1:0] want);
    compares++;
    if (got !== want) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : check

  // Burst write of n bytes; the shadow follows the writable bits of each index.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d [4], input int n);
    int k;
    host.start_cond();
    host.send_byte({DEV_ADDR_DEFAULT, 1'b0}, a);
    check(IMG_W'(a), IMG_W'(1'b1));
    host.send_byte(idx, a);
    check(IMG_W'(a), IMG_W'(1'b1));
    for (int i = 0; i < n; i++) begin
      host.send_byte(d[i], a);
      check(IMG_W'(a), IMG_W'(1'b1));
      k = int'(idx) + i;
      if (k < REG_COUNT) begin
        exp_img[8*k +: 8] = (exp_img[8*k +: 8] & ~WRITE_MASK[8*k +: 8])
                          | (d[i] & WRITE_MASK[8*k +: 8]);
      end
    end
    host.stop_cond();
    check(reg_image, exp_img);
  endtask : wr

  // Read of n bytes after a repeated start; every byte should repeat one index.
  task automatic rd(input logic [7:0] idx, input int n, input logic [7:0] want);
    logic [7:0] b;
    host.start_cond();
    host.send_byte({DEV_ADDR_DEFAULT, 1'b0}, a);
    host.send_byte(idx, a);
    host.start_cond();
    host.send_byte({DEV_ADDR_DEFAULT, 1'b1}, a);
    check(IMG_W'(a), IMG_W'(1'b1));
    for (int i = 0; i < n; i++) begin
      host.recv_byte(i == n - 1, b);
      check(IMG_W'(b), IMG_W'(want));
    end
    host.stop_cond();
  endtask : rd

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // The whole sequence needs about 7600 cycles; this leaves ample margin.
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    compares = 0;
    bad_count = 0;
    sys_rst = 1'b1;
    otp_load = 1'b0;
    otp_image = '0;
    exp_img = RESET_IMAGE;
    repeat (10) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    check(reg_image, RESET_IMAGE);
    // Single writes and read backs, read-only and unmapped places among them.
    foreach (rows[r]) begin
      wr(rows[r][23:16], '{rows[r][15:8], 8'h00, 8'h00, 8'h00}, 1);
      rd(rows[r][23:16], 1, rows[r][7:0]);
    end
    // Bursts, the second running past the last register.
    wr(8'h0c, '{8'h11, 8'h22, 8'h33, 8'h44}, 4);
    wr(8'h13, '{8'ha5, 8'hc3, 8'hff, 8'h00}, 3);
    rd(8'h0d, 3, 8'h22);
    // Another slave address must go unanswered.
    host.start_cond();
    host.send_byte({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, a);
    check(IMG_W'(a), '0);
    host.stop_cond();
    // Programmed bits replace only their own positions.
    otp_image = {REG_COUNT{8'h96}};
    otp_load = 1'b1;
    @(posedge sys_clk);
    #1;
    otp_load = 1'b0;
    exp_img = (exp_img & ~OTP_MASK) | (otp_image & OTP_MASK);
    repeat (2) @(posedge sys_clk);
    #1;
    check(reg_image, exp_img);
    rd(8'h01, 1, 8'h96);
    // Reset in mid-run restores the fixed image and releases the wire.
    sys_rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    check(reg_image, RESET_IMAGE);
    check(IMG_W'(sda_oe), '0);
    close_out();
  end
endmodule : i2c_register_bank_autoinc_test

// *** bench/irb_host_model.sv ***
// Serial bus host model: drives the clock and data lines like an open-drain master.
// Assumes the bench resolves the data wire from this drive and the device pull-down.
`timescale 1ns/100ps
module irb_host_model (
  input  wire logic sys_clk,   // System clock that paces every serial level.
  input  wire logic sda_wire,  // Resolved data wire level.
  output logic      scl_drv,   // Serial clock; high rests on the pull-up.
  output logic      sda_drv    // Data drive; high means released.
);
  ////////////////////////////////////////////////////////////////////////////
  // Each serial level lasts at least four clocks, twice the minimum the device needs.
  localparam int HALF = 4;

  // Both lines rest high between frames and the clock stands still there.
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // Waits n edges, then steps just past the last so no change races an edge.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // One clock pulse; data moves only while the clock is low.
  task automatic bit_cycle(input logic b, output logic seen);
    tick(1);
    sda_drv = b;
    tick(HALF);
    scl_drv = 1'b1;
    tick(HALF);
    seen = sda_wire;
    scl_drv = 1'b0;
  endtask : bit_cycle

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond();
    tick(1);
    sda_drv = 1'b1;
    tick(HALF);
    scl_drv = 1'b1;
    tick(HALF);
    sda_drv = 1'b0;
    tick(HALF);
    scl_drv = 1'b0;
  endtask : start_cond

  // Stop: data rises while the clock is high, leaving the bus idle.
  task automatic stop_cond();
    tick(1);
    sda_drv = 1'b0;
    tick(HALF);
    scl_drv = 1'b1;
    tick(HALF);
    sda_drv = 1'b1;
    tick(HALF);
  endtask : stop_cond

  // Eight bits, most significant first, then a released ninth bit for the answer.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], s);
    end
    bit_cycle(1'b1, s);
    ack = (s === 1'b0);
  endtask : send_byte

  // Reads eight bits; a low ninth bit asks for more, a high one ends the read.
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      b[i] = s;
    end
    bit_cycle(last, s);
  endtask : recv_byte
endmodule : irb_host_model

// *** src/irb_bank_top.sv ***
// Serial slave and register bank of the power-management controller.
// Assumes scl_in and sda_in are already synchronous to sys_clk and that
// every serial level lasts at least two clock cycles.
//
// Behaviour
// - Store each written byte, then advance index.
// - Reads never advance the register index.
// - Acknowledge address, register and every data byte.
// - All control held in serially reachable bytes.
// - Fixed reset values; programmed bits load separately.
// - Seven-bit address, direction bit, register, data.
`timescale 1ns/100ps
module irb_bank_top
  import irb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT  // Slave address on the bus.
)(
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             scl_in,     // Serial clock level.
  input  wire logic             sda_in,     // Serial data level on the wire.
  output logic                  sda_out,    // Data driven when enabled, always low.
  output logic                  sda_oe,     // High while pulling the data line.
  input  wire logic             otp_load,   // One-cycle load of programmed bits.
  input  wire logic [IMG_W-1:0] otp_image,  // Programmed register values.
  output logic      [IMG_W-1:0] reg_image   // All register contents.
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the serial engine.
  irb_state_type state;          // Position within the transfer.
  irb_state_type next_state;
  logic [3:0]    bit_cnt;        // Clock rises seen in the current byte.
  logic [3:0]    next_bit_cnt;
  logic [7:0]    shift;          // Byte being received or sent.
  logic [7:0]    next_shift;
  logic [7:0]    index;          // Register index counter.
  logic [7:0]    next_index;
  logic          rw;             // Direction taken from the address byte.
  logic          next_rw;
  logic          master_ack;     // Host acknowledged the last read byte.
  logic          next_master_ack;
  logic          next_sda_oe;
  logic          wr_en;          // Write strobe to the store.
  logic          next_wr_en;
  logic          scl_prev;       // Previous samples for edge detection.
  logic          sda_prev;
  logic [7:0]    rd_data;        // Byte at the current index.

  // Bus events derived from the current and previous samples.
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_comb begin
    scl_rise  = scl_in & ~scl_prev;
    scl_fall  = ~scl_in & scl_prev;
    start_det = scl_in & scl_prev & sda_prev & ~sda_in;
    stop_det  = scl_in & scl_prev & ~sda_prev & sda_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the serial engine.
  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shift      = shift;
    next_index      = index;
    next_rw         = rw;
    next_master_ack = master_ack;
    next_sda_oe     = sda_oe;
    next_wr_en      = 1'b0;
    // The byte is stored at the old index on this same edge; the index moves on with it.
    if (wr_en) begin
      next_index = index + 8'h01;
    end
    if (stop_det) begin
      // A stop always frees the line and ends the transfer.
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_det) begin
      // A repeated start behaves exactly like a first start.
      next_state   = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sda_oe = 1'b0;
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          // Bits arrive most significant first, taken on the rising clock.
          if (scl_rise) begin
            next_shift   = {shift[6:0], sda_in};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && (bit_cnt == BITS_PER_BYTE)) begin
            if (state == ST_ADDR) begin
              if (shift[7:1] == DEV_ADDR) begin
                // Low direction bit is a write, high a read.
                next_rw     = shift[0];
                next_sda_oe = 1'b1;
                next_state  = ST_ADDR_ACK;
              end else begin
                // Another slave is addressed; stay off the line.
                next_state = ST_IDLE;
              end
            end else if (state == ST_REG) begin
              // Second byte selects the register.
              next_index  = shift;
              next_sda_oe = 1'b1;
              next_state  = ST_REG_ACK;
            end else begin
              // Every data byte is acknowledged, mapped or not.
              next_wr_en  = 1'b1;
              next_sda_oe = 1'b1;
              next_state  = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
          // The acknowledge is held through the ninth clock and released after.
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            next_sda_oe  = 1'b0;
            if (state == ST_ADDR_ACK && rw) begin
              next_shift  = rd_data;
              next_sda_oe = ~rd_data[7];
              next_state  = ST_RDATA;
            end else if (state == ST_ADDR_ACK) begin
              next_state = ST_REG;
            end else begin
              next_state = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          // Open drain: the line is pulled only for zero bits.
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && (bit_cnt == BITS_PER_BYTE)) begin
            next_sda_oe = 1'b0;
            next_state  = ST_RDATA_ACK;
          end else if (scl_fall) begin
            next_shift  = {shift[6:0], 1'b0};
            next_sda_oe = ~shift[6];
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            next_master_ack = ~sda_in;
          end else if (scl_fall && master_ack) begin
            // Further read bytes repeat the same register; index stays.
            next_shift   = rd_data;
            next_sda_oe  = ~rd_data[7];
            next_bit_cnt = 4'h0;
            next_state   = ST_RDATA;
          end else if (scl_fall) begin
            // A not-acknowledge ends the read; wait for stop or start.
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state  = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers of the serial engine; the idle bus is high on both wires.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      index      <= 8'h00;
      rw         <= 1'b0;
      master_ack <= 1'b0;
      sda_oe     <= 1'b0;
      sda_out    <= 1'b0;
      wr_en      <= 1'b0;
      scl_prev   <= 1'b1;
      sda_prev   <= 1'b1;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shift      <= next_shift;
      index      <= next_index;
      rw         <= next_rw;
      master_ack <= next_master_ack;
      sda_oe     <= next_sda_oe;
      sda_out    <= 1'b0;
      wr_en      <= next_wr_en;
      scl_prev   <= scl_in;
      sda_prev   <= sda_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register store; reads and writes share the one index counter.
  irb_reg_mem u_mem (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .wr_en     (wr_en),
    .wr_addr   (index),
    .wr_data   (shift),
    .rd_addr   (index),
    .rd_data   (rd_data),
    .otp_load  (otp_load),
    .otp_image (otp_image),
    .reg_image (reg_image)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_index_advance;
    @(posedge sys_clk) disable iff (sys_rst)
      (wr_en && !stop_det && !start_det) |=> (index == $past(index) + 8'h01);
  endproperty
  a_index_advance: assert property (p_index_advance)
    else $error("index did not advance after a stored byte");

  property p_read_index_still;
    @(posedge sys_clk) disable iff (sys_rst)
      (state == ST_RDATA || state == ST_RDATA_ACK) |=> (index == $past(index));
  endproperty
  a_read_index_still: assert property (p_read_index_still)
    else $error("index moved during a read");

  property p_data_ack;
    @(posedge sys_clk) disable iff (sys_rst)
      (state == ST_WDATA && scl_fall && bit_cnt == BITS_PER_BYTE && !start_det) |=>
        (sda_oe && wr_en && state == ST_WDATA_ACK) ##1 (wr_en == 1'b0);
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("data byte not acknowledged");

  property p_reg_ack;
    @(posedge sys_clk) disable iff (sys_rst)
      (state == ST_REG && scl_fall && bit_cnt == BITS_PER_BYTE && !start_det) |=>
        (sda_oe && index == $past(shift));
  endproperty
  a_reg_ack: assert property (p_reg_ack)
    else $error("register byte not taken and acknowledged");

  property p_addr_miss;
    @(posedge sys_clk) disable iff (sys_rst)
      (state == ST_ADDR && scl_fall && bit_cnt == BITS_PER_BYTE && !start_det &&
       shift[7:1] != DEV_ADDR) |=> (state == ST_IDLE && !sda_oe);
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign address was answered");

  property p_read_load;
    @(posedge sys_clk) disable iff (sys_rst)
      (state == ST_ADDR_ACK && rw && scl_fall && !start_det && !stop_det) |=>
        (shift == $past(rd_data) && sda_oe == ~$past(rd_data[7]));
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("read byte not taken from the register");

endmodule : irb_bank_top

// *** src/irb_pkg.sv ***
// Shared constants and types of the serial register bank.
// Assumes one system clock and a synchronous active-high reset.
package irb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry of the bank.
  localparam int         DATA_W        = 8;                // Every register is one byte.
  localparam int         REG_COUNT     = 21;               // Registers 0x00 to 0x14.
  localparam int         IMG_W         = REG_COUNT * DATA_W;
  localparam logic [7:0] REG_LIMIT     = 8'h15;            // First index past the map.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;             // Bits before each acknowledge.
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h60;         // Serial slave address.

  ////////////////////////////////////////////////////////////////////////////
  // Register indices.
  localparam logic [7:0] ADDR_DEVICE_REVISION         = 8'h00;
  localparam logic [7:0] ADDR_OTP_REVISION            = 8'h01;
  localparam logic [7:0] ADDR_BUCK_A_CONTROL_ONE      = 8'h02;
  localparam logic [7:0] ADDR_BUCK_A_CONTROL_TWO      = 8'h03;
  localparam logic [7:0] ADDR_BUCK_B_CONTROL_ONE      = 8'h04;
  localparam logic [7:0] ADDR_BUCK_B_CONTROL_TWO      = 8'h05;
  localparam logic [7:0] ADDR_BUCK_A_VOLTAGE_SET      = 8'h06;
  localparam logic [7:0] ADDR_BUCK_B_VOLTAGE_SET      = 8'h07;
  localparam logic [7:0] ADDR_LINREG_A_CONTROL        = 8'h08;
  localparam logic [7:0] ADDR_LINREG_B_CONTROL        = 8'h09;
  localparam logic [7:0] ADDR_LINREG_A_VOLTAGE_SET    = 8'h0a;
  localparam logic [7:0] ADDR_LINREG_B_VOLTAGE_SET    = 8'h0b;
  localparam logic [7:0] ADDR_BUCK_A_SEQUENCE_DELAYS  = 8'h0c;
  localparam logic [7:0] ADDR_BUCK_B_SEQUENCE_DELAYS  = 8'h0d;
  localparam logic [7:0] ADDR_LINREG_A_SEQUENCE_DELAYS = 8'h0e;
  localparam logic [7:0] ADDR_LINREG_B_SEQUENCE_DELAYS = 8'h0f;
  localparam logic [7:0] ADDR_OUTPUT_A_SEQUENCE_DELAYS = 8'h10;
  localparam logic [7:0] ADDR_OUTPUT_B_SEQUENCE_DELAYS = 8'h11;
  localparam logic [7:0] ADDR_GENERAL_OUTPUT_CONTROL  = 8'h12;
  localparam logic [7:0] ADDR_GENERAL_CONFIGURATION   = 8'h13;
  localparam logic [7:0] ADDR_CLOCK_SYNC_CONTROL      = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Byte images, register 0x14 leftmost and register 0x00 rightmost.
  // Fixed values after reset; only the revision's low field is nonzero.
  localparam logic [IMG_W-1:0] RESET_IMAGE = {{20{8'h00}}, 8'h02};
  // Writable bits; reserved bits and the identification bytes stay put.
  localparam logic [IMG_W-1:0] WRITE_MASK = {
    8'h5f, 8'h7f, 8'h77, {6{8'hff}}, 8'h1f, 8'h1f, 8'h07, 8'h07,
    8'hff, 8'hff, 8'h3f, 8'h0f, 8'h3f, 8'h3f, 8'h00, 8'h00};
  // Bits whose power-up value comes from one-time-programmable memory.
  localparam logic [IMG_W-1:0] OTP_MASK = {
    {9{8'h00}}, 8'h1f, 8'h1f, {2{8'h00}}, 8'hff, 8'hff, {4{8'h00}}, 8'hff, 8'hc0};

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave states.
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_REG       = 4'h3,
    ST_REG_ACK   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA     = 4'h7,
    ST_RDATA_ACK = 4'h8
  } irb_state_type;

endpackage : irb_pkg

// *** src/irb_reg_mem.sv ***
// Byte-wide register store with a registered read port.
// Assumes the serial engine presents one write pulse per data byte.
`timescale 1ns/100ps
module irb_reg_mem
  import irb_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             wr_en,      // One-cycle write strobe.
  input  wire logic [7:0]       wr_addr,    // Register index written.
  input  wire logic [7:0]       wr_data,    // Byte written.
  input  wire logic [7:0]       rd_addr,    // Register index read.
  output logic      [7:0]       rd_data,    // Registered read byte.
  input  wire logic             otp_load,   // One-cycle load of programmed bits.
  input  wire logic [IMG_W-1:0] otp_image,  // Programmed values, same layout.
  output logic      [IMG_W-1:0] reg_image   // All registers, for the regulators.
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte selection, shared by the read port and the checks.
  function automatic logic [7:0] byte_of(input logic [IMG_W-1:0] img,
                                         input logic [7:0] idx);
    byte_of = (idx < REG_LIMIT) ? img[int'(idx) * DATA_W +: DATA_W] : 8'h00;
  endfunction : byte_of

  logic [IMG_W-1:0] next_image;   // Next value of every register.
  logic [7:0]       next_rd_data; // Next read byte.

  ////////////////////////////////////////////////////////////////////////////
  // One update path per register; the programmed load wins over a write.
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
    localparam logic [7:0] IDX = 8'(g);
    localparam logic [7:0] WM  = WRITE_MASK[g*DATA_W +: DATA_W];
    localparam logic [7:0] OM  = OTP_MASK[g*DATA_W +: DATA_W];
    always_comb begin
      next_image[g*DATA_W +: DATA_W] = reg_image[g*DATA_W +: DATA_W];
      if (otp_load) begin
        // Programmed bits take their values, the rest keep theirs.
        next_image[g*DATA_W +: DATA_W] = (reg_image[g*DATA_W +: DATA_W] & ~OM) |
                                         (otp_image[g*DATA_W +: DATA_W] & OM);
      end else if (wr_en && (wr_addr == IDX)) begin
        // Read-only and reserved bits are masked, so such writes change nothing.
        next_image[g*DATA_W +: DATA_W] = (reg_image[g*DATA_W +: DATA_W] & ~WM) |
                                         (wr_data & WM);
      end
    end
  end

  // Read byte is looked up every cycle; indices past the map read zero.
  always_comb begin
    next_rd_data = byte_of(reg_image, rd_addr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers of the store.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_image <= RESET_IMAGE;
      rd_data   <= 8'h00;
    end else begin
      reg_image <= next_image;
      rd_data   <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_write_lands;
    @(posedge sys_clk) disable iff (sys_rst)
      (wr_en && !otp_load && (wr_addr < REG_LIMIT)) |=>
        ((byte_of(reg_image, $past(wr_addr)) & byte_of(WRITE_MASK, $past(wr_addr))) ==
         ($past(wr_data) & byte_of(WRITE_MASK, $past(wr_addr))));
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("written byte did not land in its register");

  property p_read_only;
    @(posedge sys_clk) disable iff (sys_rst)
      (wr_en && !otp_load && (wr_addr < ADDR_BUCK_A_CONTROL_ONE)) |=>
        (reg_image == $past(reg_image));
  endproperty
  a_read_only: assert property (p_read_only)
    else $error("write changed an identification register");

  property p_otp_load;
    @(posedge sys_clk) disable iff (sys_rst)
      otp_load |=> ((reg_image & OTP_MASK) == ($past(otp_image) & OTP_MASK));
  endproperty
  a_otp_load: assert property (p_otp_load)
    else $error("programmed bits not taken from the load");

endmodule : irb_reg_mem
